// ===== hw/mcar_pkg.sv
// Package for the memory controller abort/remap/flash-read block.
// Assumes an APB register bus with 32-bit data and one clock domain.
package mcar_pkg;
  // Register byte offsets
  localparam logic [7:0] REMAP_COMMAND_OFS = 8'h00;
  localparam logic [7:0] ABORT_STATUS_OFS  = 8'h04;
  localparam logic [7:0] ABORT_ADDRESS_OFS = 8'h08;
  localparam logic [7:0] FLASH_MODE_OFS    = 8'h60;
  // Field positions
  localparam int REMAP_TOGGLE_BIT   = 0;
  localparam int UNDEF_POS          = 0;
  localparam int MISAL_POS          = 1;
  localparam int SIZE_LO            = 8;
  localparam int TYPE_LO            = 10;
  localparam int DMA_SRC_POS        = 16;
  localparam int CPU_SRC_POS        = 17;
  localparam int DMA_SEEN_POS       = 24;
  localparam int CPU_SEEN_POS       = 25;
  localparam int FWS_LO             = 8;
  // Reset values
  localparam logic [31:0] ABORT_STATUS_RST  = 32'h0000_0000;
  localparam logic [31:0] ABORT_ADDRESS_RST = 32'h0000_0000;
  localparam logic [1:0]  FWS_RST           = 2'h0;
  // Access sizes and types
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] TY_READ  = 2'h0;
  localparam logic [1:0] TY_WRITE = 2'h1;
  localparam logic [1:0] TY_FETCH = 2'h2;
  // Memory map
  localparam logic [3:0] AREA_INTERNAL = 4'h0;
  localparam logic [3:0] AREA_PERIPH   = 4'hf;
  localparam logic [7:0] SLOT_BOOT     = 8'h00;
  localparam logic [7:0] SLOT_FLASH    = 8'h01;
  localparam logic [7:0] SLOT_SRAM     = 8'h02;
  localparam int FLASH_AW   = 16;   // Flash words, 256 kbyte
  localparam int SRAM_AW    = 14;   // SRAM words, 64 kbyte
  localparam int PAGE_AW    = 6;    // Page buffer words, 256 byte
  localparam int LOCK_BITS  = 16;
  localparam int GPNVM_BITS = 2;
  // Flash-read state
  typedef enum logic [1:0] {MCAR_IDLE, MCAR_WAIT, MCAR_DONE} mcar_fstate_t;
endpackage : mcar_pkg

// ===== hw/mcar_top.sv
// Memory controller: remap, abort capture, flash read path with buffers.
// Assumes APB from the system, one master request port (DMA wins arbitration
// upstream), and flash/SRAM arrays that answer combinationally.
// Operation
// - Writing one toggles page-zero remap
// - Bit 0 flags undefined address abort
// - Bit 1 flags misaligned address abort
// - Bits 9:8 hold aborted access size
// - Bits 11:10 hold aborted access type
// - Bit 16 marks DMA-issued last abort
// - Bit 17 marks CPU-issued last abort
// - Bit 24 earlier unreported DMA abort, read-cleared
// - Bit 25 earlier unreported CPU abort, read-cleared
// - Abort address holds full aborted address
// - Two word buffers; an even miss prefetches the odd next word
// - Read-ahead only for instruction fetches
// - Wait states 0-3, zero gives single-cycle
// - One wait state: sequential fetches also alternate long, short
// - Two/three wait states alternate long, short
// - Flash serves byte, half, word reads
// - Flash image repeats across its region
// - Write-only page buffer anywhere in region
// - Lock bits per region, two GP bits
// - Flash at zero, SRAM after remap
// - Misaligned data accesses abort, fetches exempt
// - Undefined areas return abort
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module mcar_top
  import mcar_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  req_valid,
  input  wire logic                  req_dma,
  input  wire logic                  req_write,
  input  wire logic [1:0]            req_size,
  input  wire logic                  req_fetch,
  input  wire logic [31:0]           req_addr,
  input  wire logic [31:0]           req_wdata,
  output logic                       req_ready,
  output logic      [31:0]           req_rdata,
  output logic                       req_abort,
  output logic                       remap_active,
  output logic [FLASH_AW-1:0]        flash_addr,
  input  wire logic [31:0]           flash_data,
  output logic                       sram_we,
  output logic [SRAM_AW-1:0]         sram_addr,
  output logic [31:0]                sram_wdata,
  input  wire logic [31:0]           sram_data,
  input  wire logic [LOCK_BITS-1:0]  lock_bits,
  input  wire logic [GPNVM_BITS-1:0] gpnvm_bits,
  output logic                       page_locked
);
  logic                 remap;
  logic [31:0]          abort_status;
  logic [31:0]          abort_address;
  logic [1:0]           flash_wait_states;
  logic [31:0]          page_buffer [2**PAGE_AW];
  logic [31:0]          buf_word [2];
  logic [FLASH_AW-2:0]  buf_pair;
  logic                 buf_valid [2];
  logic                 pf_pending;
  logic [FLASH_AW-1:0]  pf_addr;
  logic                 abort_fresh;
  logic [1:0]           wcnt;
  mcar_fstate_t         fstate;

  // APB decode; single-cycle answer
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic ofs_known;
  assign apb_acc   = psel && penable;
  assign apb_wr    = apb_acc && pwrite;
  assign apb_rd    = apb_acc && !pwrite;
  assign pready    = 1'b1;
  assign ofs_known = (paddr[7:0] == REMAP_COMMAND_OFS) || (paddr[7:0] == ABORT_STATUS_OFS) ||
                     (paddr[7:0] == ABORT_ADDRESS_OFS) || (paddr[7:0] == FLASH_MODE_OFS);
  assign pslverr   = apb_acc && (!ofs_known || (paddr[31:8] != 24'h000000) || (paddr[1:0] != 2'h0));
  wire asr_read    = apb_rd && (paddr[7:0] == ABORT_STATUS_OFS);

  // Read mux; the remap command reads as zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd && !pslverr) begin
      unique case (paddr[7:0])
        ABORT_STATUS_OFS:  prdata = abort_status;
        ABORT_ADDRESS_OFS: prdata = abort_address;
        FLASH_MODE_OFS:    prdata = {22'h000000, flash_wait_states, 8'h00};
        default:           prdata = 32'h0000_0000;
      endcase
    end
  end

  // Remap toggles on each write of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remap <= 1'b0;
    end else if (apb_wr && !pslverr && paddr[7:0] == REMAP_COMMAND_OFS && pwdata[REMAP_TOGGLE_BIT]) begin
      remap <= !remap;
    end
  end
  assign remap_active = remap;

  // Wait-state field, two bits so only 0..3 exist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wait_states <= FWS_RST;
    end else if (apb_wr && !pslverr && paddr[7:0] == FLASH_MODE_OFS) begin
      flash_wait_states <= pwdata[FWS_LO+1:FWS_LO];
    end
  end

  // Address decode of the master request
  logic [3:0] area;
  logic [7:0] slot;
  logic       undefined;
  logic       misaligned;
  logic       to_flash;
  logic       to_sram;
  assign area = req_addr[31:28];
  assign slot = req_addr[27:20];
  assign to_flash = (area == AREA_INTERNAL) && ((slot == SLOT_FLASH) || (slot == SLOT_BOOT && !remap));
  assign to_sram  = (area == AREA_INTERNAL) && ((slot == SLOT_SRAM) || (slot == SLOT_BOOT && remap));
  // Peripheral area is decoded elsewhere; only defined areas pass
  assign undefined = !(to_flash || to_sram || area == AREA_PERIPH);
  // Fetches are exempt because the processor fetch path never checks alignment
  assign misaligned = !req_fetch &&
                      (((req_size == SZ_WORD) && (req_addr[1:0] != 2'h0)) ||
                       ((req_size == SZ_HALF) && req_addr[0]));
  wire abort_now = req_valid && (undefined || misaligned);
  assign req_abort = abort_now;

  // Abort capture: every field in one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_status  <= ABORT_STATUS_RST;
      abort_address <= ABORT_ADDRESS_RST;
    end else begin
      if (abort_now) begin
        abort_address                       <= req_addr;
        abort_status[UNDEF_POS]             <= undefined;
        abort_status[MISAL_POS]             <= misaligned && !undefined;
        abort_status[SIZE_LO+1:SIZE_LO]     <= req_size;
        abort_status[TYPE_LO+1:TYPE_LO]     <= req_fetch ? TY_FETCH : (req_write ? TY_WRITE : TY_READ);
        abort_status[DMA_SRC_POS]           <= req_dma;
        abort_status[CPU_SRC_POS]           <= !req_dma;
      end
      // A displaced report counts only if it came after the last read
      // A set beats a read clear in the same cycle
      abort_status[DMA_SEEN_POS] <= (abort_now && abort_status[DMA_SRC_POS] && abort_fresh) ||
                                    (abort_status[DMA_SEEN_POS] && !asr_read);
      abort_status[CPU_SEEN_POS] <= (abort_now && abort_status[CPU_SRC_POS] && abort_fresh) ||
                                    (abort_status[CPU_SEEN_POS] && !asr_read);
    end
  end

  // Report not yet read by software
  // An abort in the same cycle as the read stays unread, since the read shows the old one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_fresh <= 1'b0;
    end else if (abort_now) begin
      abort_fresh <= 1'b1;
    end else if (asr_read) begin
      abort_fresh <= 1'b0;
    end
  end

  // Flash region mirrors every 2**FLASH_AW words (256 kbyte)
  wire [FLASH_AW-1:0] fw = req_addr[FLASH_AW+1:2];
  wire flash_rd = req_valid && !abort_now && to_flash && !req_write;
  wire flash_wr = req_valid && !abort_now && to_flash && req_write;
  // Fetch hitting a valid word of the buffered pair; data reads never hit
  wire buf_hit  = buf_valid[fw[0]] && req_fetch && (fw[FLASH_AW-1:1] == buf_pair);

  // Flash read sequencer: a miss takes three cycles at one or two wait states, four at three; one for a buffer hit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fstate <= MCAR_IDLE;
      wcnt   <= 2'h0;
    end else begin
      unique case (fstate)
        MCAR_IDLE: if (flash_rd && !buf_hit && flash_wait_states != 2'h0) begin
          fstate <= MCAR_WAIT;
          wcnt   <= flash_wait_states - 2'h1;
        end
        MCAR_WAIT: if (wcnt <= 2'h1) begin
          fstate <= MCAR_DONE;
        end else begin
          wcnt <= wcnt - 2'h1;
        end
        MCAR_DONE: fstate <= MCAR_IDLE;
      endcase
    end
  end
  wire flash_done = (fstate == MCAR_DONE) || (fstate == MCAR_IDLE && (buf_hit || flash_wait_states == 2'h0));

  // Fetch miss keeps the word it read; an even miss then reads its odd partner ahead.
  // The array port has one address, so the read-ahead takes the first idle cycle
  // and is dropped if a request comes first. It is captured in one clock, which
  // assumes the array settles like a zero-wait read.
  wire fill_miss = flash_rd && flash_done && req_fetch && !buf_hit && (flash_wait_states != 2'h0);

  // Buffer pair; data reads never refill it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_valid[0] <= 1'b0;
      buf_valid[1] <= 1'b0;
      buf_pair     <= '0;
      buf_word[0]  <= 32'h0000_0000;
      buf_word[1]  <= 32'h0000_0000;
    end else if (fill_miss) begin
      buf_pair          <= fw[FLASH_AW-1:1];
      buf_word[fw[0]]   <= flash_data;
      buf_valid[fw[0]]  <= 1'b1;
      buf_valid[~fw[0]] <= 1'b0;
    end else if (flash_wr) begin
      buf_valid[0] <= 1'b0;
      buf_valid[1] <= 1'b0;
    end else if (pf_pending && !req_valid) begin
      buf_word[1]  <= flash_data;
      buf_valid[1] <= 1'b1;
    end
  end

  // Read-ahead request for the odd word of the pair just filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_pending <= 1'b0;
      pf_addr    <= '0;
    end else if (fill_miss && !fw[0]) begin
      pf_pending <= 1'b1;
      pf_addr    <= {fw[FLASH_AW-1:1], 1'b1};
    end else begin
      pf_pending <= 1'b0;
    end
  end

  // Page buffer wraps on page size, words only
  always_ff @(posedge pclk) begin
    if (flash_wr && req_size == SZ_WORD) begin
      page_buffer[req_addr[PAGE_AW+1:2]] <= req_wdata;
    end
  end

  // Lock region of the addressed page
  assign page_locked = lock_bits[fw[FLASH_AW-1 -: 4]] && (gpnvm_bits != 2'h3 || 1'b1);
  // Idle cycles lend the array port to the read-ahead
  assign flash_addr  = (pf_pending && !req_valid) ? pf_addr : fw;
  assign sram_addr   = req_addr[SRAM_AW+1:2];
  assign sram_wdata  = req_wdata;
  assign sram_we     = req_valid && !abort_now && to_sram && req_write;

  // Handshake and read data lane select for byte/half reads
  wire [31:0] raw = to_flash ? (buf_hit ? buf_word[fw[0]] : flash_data) : sram_data;
  assign req_ready = !req_valid || abort_now || !flash_rd || flash_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_rdata <= 32'h0000_0000;
    end else if (req_valid && req_ready && !req_write) begin
      req_rdata <= (req_size == SZ_WORD) ? raw :
                   (req_size == SZ_HALF) ? {16'h0000, raw[req_addr[1]*16 +: 16]} :
                   {24'h000000, raw[req_addr[1:0]*8 +: 8]};
    end
  end

  // Checks
  AST_REMAP_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr && !pslverr && paddr[7:0] == REMAP_COMMAND_OFS |=> remap == !$past(remap) || !$past(pwdata[0]))
    else $error("remap did not toggle");
  AST_UNDEF: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && undefined |=> abort_status[UNDEF_POS]) else $error("undef flag");
  AST_MISAL: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && !undefined |=> abort_status[MISAL_POS]) else $error("misalign flag");
  AST_SIZE: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now |=> abort_status[9:8] == $past(req_size)) else $error("size field");
  AST_TYPE: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && req_fetch |=> abort_status[11:10] == TY_FETCH) else $error("type field");
  AST_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now |=> abort_status[DMA_SRC_POS] != abort_status[CPU_SRC_POS]) else $error("source bits");
  AST_CPU_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && !req_dma |=> abort_status[CPU_SRC_POS]) else $error("cpu source");
  AST_SEEN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    asr_read && !abort_now |=> !abort_status[CPU_SEEN_POS]) else $error("seen not cleared");
  AST_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now |=> abort_address == $past(req_addr)) else $error("abort address");
  AST_FWS0: assert property (@(posedge pclk) disable iff (!presetn)
    flash_rd && flash_wait_states == 2'h0 |-> req_ready) else $error("fws0 not single cycle");
  AST_FETCH_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && req_fetch && !undefined |-> !req_abort) else $error("fetch aborted");

  // Steps of a flash miss and of the read-ahead
  sequence s_flash_miss;
    fstate == MCAR_IDLE && flash_rd && !buf_hit && flash_wait_states != 2'h0;
  endsequence

  sequence s_read_ahead;
    pf_pending && !req_valid;
  endsequence

  AST_DMA_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && req_dma |=> abort_status[DMA_SRC_POS] && !abort_status[CPU_SRC_POS])
    else $error("dma source");

  AST_DMA_SEEN_SET: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && abort_status[DMA_SRC_POS] && abort_fresh |=> abort_status[DMA_SEEN_POS])
    else $error("dma seen not set");

  AST_DMA_SEEN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    asr_read && !abort_now |=> !abort_status[DMA_SEEN_POS])
    else $error("dma seen not cleared");

  AST_CPU_SEEN_SET: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now && abort_status[CPU_SRC_POS] && abort_fresh |=> abort_status[CPU_SEEN_POS])
    else $error("cpu seen not set");

  AST_ADDR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !abort_now |=> $stable(abort_address))
    else $error("abort address moved");

  AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    abort_now |=> abort_address == $past(req_addr) && abort_status[DMA_SRC_POS] == $past(req_dma))
    else $error("abort fields split");

  AST_MISS_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    s_flash_miss |-> !req_ready)
    else $error("miss answered early");

  AST_MISS_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    s_flash_miss |=> ##[0:2] (fstate == MCAR_DONE))
    else $error("miss never done");

  AST_HIT_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    flash_rd && buf_hit |-> req_ready)
    else $error("buffer hit not single cycle");

  AST_DATA_NO_HIT: assert property (@(posedge pclk) disable iff (!presetn)
    flash_rd && !req_fetch |-> !buf_hit)
    else $error("data read used buffer");

  AST_READ_AHEAD: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_ahead |=> buf_valid[1] && buf_word[1] == $past(flash_data))
    else $error("read-ahead lost");

  AST_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && to_flash |-> flash_addr == req_addr[FLASH_AW+1:2])
    else $error("flash not mirrored");

  AST_BOOT_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && area == AREA_INTERNAL && slot == SLOT_BOOT |-> to_sram == remap && to_flash == !remap)
    else $error("boot slot mapping");

  AST_PAGE_BUF: assert property (@(posedge pclk) disable iff (!presetn)
    flash_wr && req_size == SZ_WORD |=> page_buffer[$past(req_addr[PAGE_AW+1:2])] == $past(req_wdata))
    else $error("page buffer write");

  AST_WORD_READ: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && req_ready && !req_write && req_size == SZ_WORD |=> req_rdata == $past(raw))
    else $error("word read data");
endmodule : mcar_top

// ===== dv/mcar_mem_model.sv
// Flash and SRAM arrays that face the memory controller's array ports.
// Assumes the controller reads them combinationally and writes on the edge.
`timescale 1ns/1ps
module mcar_mem_model
  import mcar_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic [FLASH_AW-1:0] flash_addr,
  output logic      [31:0]         flash_data,
  input  wire logic                sram_we,
  input  wire logic [SRAM_AW-1:0]  sram_addr,
  input  wire logic [31:0]         sram_wdata,
  output logic      [31:0]         sram_data
);
  logic [31:0] sram_mem [0:255]; // Low words only, to keep the model small
  // Flash content is a pattern of its word address, easy to predict
  assign flash_data = {16'hc3a5, flash_addr};
  assign sram_data  = sram_mem[sram_addr[7:0]];
  // Word write on the edge
  always_ff @(posedge pclk) begin
    if (sram_we) begin
      sram_mem[sram_addr[7:0]] <= sram_wdata;
    end
  end
endmodule : mcar_mem_model

// ===== dv/tb_memctrl_abort_remap_flash_read.sv
// Self-checking bench for the memory controller abort, remap and flash read path.
// Assumes mcar_top with APB registers and the array model on its far side.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_memctrl_abort_remap_flash_read;
  import mcar_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, req_rdata, req_addr = 32'h0, req_wdata = 32'h0;
  logic req_valid = 1'b0, req_dma = 1'b0, req_write = 1'b0, req_fetch = 1'b0, req_ready, req_abort, remap_active;
  logic [1:0] req_size = 2'h0;
  logic [FLASH_AW-1:0] flash_addr;
  logic [SRAM_AW-1:0] sram_addr;
  logic [31:0] flash_data, sram_wdata, sram_data, q;
  logic sram_we, e, ab;
  int errors = 0, n_checks = 0, cycles = 0, cyc;
  mcar_top i_mcar_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_dma(req_dma), .req_write(req_write), .req_size(req_size), .req_fetch(req_fetch), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_rdata(req_rdata), .req_abort(req_abort),
    .remap_active(remap_active), .flash_addr(flash_addr), .flash_data(flash_data), .sram_we(sram_we),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_data(sram_data), .lock_bits(16'h0000),
    .gpnvm_bits(2'h0), .page_locked());
  mcar_mem_model i_mcar_mem_model (.pclk(pclk), .flash_addr(flash_addr), .flash_data(flash_data),
    .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_data(sram_data));
  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // APB transfer; request held until pready is seen high at a rising edge, answer taken there
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Master request held until ready; cyc counts cycles up to the handshake
  task automatic mreq(input logic dma, input logic wr, input logic ft, input logic [1:0] sz,
                      input logic [31:0] a, input logic [31:0] d);
    req_valid <= 1'b1; req_dma <= dma; req_write <= wr; req_fetch <= ft; req_size <= sz;
    req_addr <= a; req_wdata <= d;
    cyc = 0;
    do begin @(posedge pclk); cyc++; end while (req_ready !== 1'b1);
    ab = req_abort;
    req_valid <= 1'b0;
    @(posedge pclk);
    q = req_rdata;
  endtask : mreq
  task automatic t_reset();
    apb(1'b0, 32'h04, 32'h0); `CHK(q, 32'h0000_0000)
    apb(1'b0, 32'h08, 32'h0); `CHK(q, 32'h0000_0000)
    apb(1'b0, 32'h10, 32'h0); `CHK(e, 1'b1)
    $display("test reset done");
  endtask : t_reset
  task automatic t_remap();
    apb(1'b1, 32'h00, 32'h0); `CHK(remap_active, 1'b0)
    apb(1'b1, 32'h00, 32'h1); `CHK(remap_active, 1'b1)
    mreq(1'b0, 1'b1, 1'b0, SZ_WORD, 32'h0020_0000, 32'h1234_5678);
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h0000_0000, 32'h0); `CHK(q, 32'h1234_5678)
    apb(1'b1, 32'h00, 32'h1); `CHK(remap_active, 1'b0)
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h0000_0000, 32'h0); `CHK(q, 32'hc3a5_0000)
    $display("test remap done");
  endtask : t_remap
  task automatic t_abort();
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h2000_0004, 32'h0); `CHK(ab, 1'b1)
    apb(1'b0, 32'h04, 32'h0); `CHK(q, 32'h0002_0201)
    apb(1'b0, 32'h08, 32'h0); `CHK(q, 32'h2000_0004)
    mreq(1'b1, 1'b1, 1'b0, SZ_HALF, 32'h0010_0003, 32'h0); `CHK(ab, 1'b1)
    apb(1'b0, 32'h04, 32'h0); `CHK(q, 32'h0001_0502)
    mreq(1'b1, 1'b0, 1'b0, SZ_WORD, 32'h0020_0002, 32'h0);
    mreq(1'b1, 1'b0, 1'b0, SZ_BYTE, 32'h3000_0000, 32'h0);
    apb(1'b0, 32'h04, 32'h0); `CHK(q, 32'h0101_0001)
    apb(1'b0, 32'h04, 32'h0); `CHK(q, 32'h0001_0001)
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h4000_0000, 32'h0);
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h4000_0010, 32'h0);
    apb(1'b0, 32'h04, 32'h0); `CHK(q, 32'h0202_0a01)
    apb(1'b0, 32'h08, 32'h0); `CHK(q, 32'h4000_0010)
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h0010_0002, 32'h0); `CHK(ab, 1'b0)
    $display("test abort done");
  endtask : t_abort
  task automatic t_flash();
    apb(1'b1, 32'h60, 32'h0000_0000);
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h0010_0010, 32'h0); `CHK(cyc, 1)
    `CHK(q, 32'hc3a5_0004)
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h0014_0010, 32'h0); `CHK(q, 32'hc3a5_0004)
    mreq(1'b0, 1'b0, 1'b0, SZ_BYTE, 32'h0010_0011, 32'h0); `CHK(ab, 1'b0)
    apb(1'b1, 32'h60, 32'h0000_0200);
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h0010_0020, 32'h0); `CHK(cyc > 1, 1'b1)
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h0010_0024, 32'h0); `CHK(cyc, 1)
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h0010_0040, 32'h0);
    mreq(1'b0, 1'b0, 1'b0, SZ_WORD, 32'h0010_0044, 32'h0); `CHK(cyc > 1, 1'b1)
    apb(1'b1, 32'h60, 32'h0000_0100);
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h0010_0080, 32'h0);
    mreq(1'b0, 1'b0, 1'b1, SZ_WORD, 32'h0010_0084, 32'h0); `CHK(cyc, 1)
    `CHK(q, 32'hc3a5_0021)
    $display("test flash done");
  endtask : t_flash
  // Main sequence: reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_remap();
    t_abort();
    t_flash();
    test_done();
  end
endmodule : tb_memctrl_abort_remap_flash_read
